// ---- src/ihp_pkg.sv ----
`default_nettype none
package ihp_pkg;
    localparam int CLK_MHZ = 100;
    localparam int BCLK_KHZ = 8330;
    // Host bus clock half period in pclk cycles
    localparam int BCLK_HALF_CYC = (CLK_MHZ * 1000) / (2 * BCLK_KHZ);
    localparam int STROBE_BCLK = 2;
    localparam int DEV_WAIT_BCLK = 1;
    localparam logic [13:0] CODE_OFS = 14'h1000;
    localparam logic [13:0] CREG_CTRL_OFS = 14'h0000;
    localparam logic [13:0] CREG_IRQ_OFS = 14'h0001;
    localparam logic [13:0] CREG_LAST_OFS = 14'h0003;
    localparam int RUN_BIT = 0;
    localparam int MODE_LSB = 1;
    localparam int IRQ_EN_BIT = 3;
    localparam int GATE_BIT = 4;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [3:0] IRQ_SEL_RST = 4'h0;
    localparam logic [5:0] BASE_RST = 6'h00;
    localparam logic [7:0] LOCKED_RDATA = 8'hff;
    localparam int N_IRQ = 11;
    // Request line number of each open-drain output, 4 bits each
    localparam logic [43:0] IRQ_NUMS = {4'hf, 4'he, 4'hc, 4'hb, 4'ha, 4'h9, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3};
    // Jumper code to six upper address bits
    localparam logic [95:0] BASE_TABLE = {6'h3b, 6'h3a, 6'h39, 6'h38, 6'h37, 6'h36, 6'h35, 6'h34,
                                          6'h33, 6'h32, 6'h2d, 6'h2c, 6'h2b, 6'h2a, 6'h29, 6'h00};
    localparam logic [11:0] H_ADDR_OFS = 12'h000;
    localparam logic [11:0] H_WDATA_OFS = 12'h004;
    localparam logic [11:0] H_CTRL_OFS = 12'h008;
    localparam logic [11:0] H_STAT_OFS = 12'h00c;
    localparam logic [11:0] H_IRQ_OFS = 12'h010;
    localparam int H_GO = 0;
    localparam int H_WR = 1;
    localparam int H_RFSH = 2;
    localparam int H_RST = 3;
    localparam int H_ALI = 4;
    localparam logic [4:0] H_CTRL_RST = 5'h18;

    function automatic logic [5:0] ihp_base_of(input logic [3:0] j);
        return BASE_TABLE[{j, 3'b000} - {1'b0, j, 1'b0} +: 6];
    endfunction
endpackage
`default_nettype wire

// ---- src/ihp_bus_if.sv ----
`default_nettype none
interface ihp_bus_if;
    logic bclk;
    logic refresh;
    logic rstdrv;
    logic ce_n;
    logic memr_n;
    logic memw_n;
    logic addr_latch_select_in;
    logic [19:0] sa;
    logic [7:0] h_sd_o;
    logic h_sd_oe;
    logic [7:0] d_sd_o;
    logic d_sd_oe;
    logic [7:0] sd;
    logic [10:0] irq_o;
    logic [10:0] irq_oe;
    logic [10:0] irq;
    logic chrdy_o;
    logic chrdy_oe;
    logic chrdy;
    // Pull-ups on released lines
    assign sd = d_sd_oe ? d_sd_o : (h_sd_oe ? h_sd_o : 8'hff);
    assign irq = (irq_oe & irq_o) | ~irq_oe;
    assign chrdy = chrdy_oe ? chrdy_o : 1'b1;
    modport dev (input bclk, refresh, rstdrv, ce_n, memr_n, memw_n, addr_latch_select_in, sa, sd,
                 output d_sd_o, d_sd_oe, irq_o, irq_oe, chrdy_o, chrdy_oe);
    modport host (output bclk, refresh, rstdrv, ce_n, memr_n, memw_n, addr_latch_select_in, sa,
                  output h_sd_o, h_sd_oe, input sd, irq, chrdy);
endinterface
`default_nettype wire

// ---- src/ihp_sync3.sv ----
`default_nettype none
module ihp_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    // Each bit moves only once the last two stages agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_r <= INIT;
            s2_r <= INIT;
            s3_r <= INIT;
            q <= INIT;
        end else if (clk_en) begin
            s1_r <= d;
            s2_r <= s1_r;
            s3_r <= s2_r;
            q <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & q);
        end
    end
endmodule
`default_nettype wire

// ---- src/ihp_device.sv ----
// Overview of operation
// - Host supplies bus clock near 8.33 MHz
// - Host marks refresh cycles on refresh input
// - Open-drain requests on lines 3-15, not 8/13
// - Host reset line resets, stays reset
// - Control bit zero holds or releases core
// - Access only while chip select low
// - Host qualifies accesses with memory strobes
// - Pull channel ready low to stretch
// - Latch select picks direct or latched address
// - Select only when upper bits match base
// - Base register from jumpers or software
// - Six base bits versus six top bits
// - Code RAM open only while core reset
// - Running core locks host from code RAM
// - Released core fetches from location zero
// - Host reset anytime stops core, clears gate bit
// - Code RAM at base plus 0x1000
// - Control bytes host-write-only, reads return RAM
// - Code access also needs gate bit set
// - External select is inverse port bit
// - Oscillator clock driven onto clock output
// - Low port muxed, third port upper address
`default_nettype none
module ihp_device
    import ihp_pkg::*;
#(
    parameter int DP_DEPTH = 256,
    parameter int CODE_DEPTH = 4096
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    ihp_bus_if.dev bus,
    input wire logic [3:0] base_select_jumpers,
    input wire logic osc_input,
    input wire logic ext_select_port_bit,
    input wire logic core_irq_req,
    input wire logic [7:0] core_dp_addr,
    input wire logic core_dp_we,
    input wire logic [7:0] core_dp_wdata,
    output logic [7:0] core_dp_rdata,
    input wire logic core_fetch_next,
    input wire logic core_jump,
    input wire logic [11:0] core_jump_addr,
    output logic [11:0] core_pc,
    output logic [7:0] core_code_byte,
    output logic core_reset_n,
    output logic [1:0] core_mode,
    input wire logic base_sw_we,
    input wire logic [5:0] base_sw_data,
    input wire logic [15:0] ext_addr,
    input wire logic [7:0] ext_wdata,
    input wire logic ext_addr_phase,
    output logic [7:0] muxed_low_port,
    output logic [7:0] upper_addr_port,
    output logic ext_sel_n,
    output logic clk_out
);
    typedef enum logic [2:0] {
        D_IDLE = 3'b001,
        D_BUSY = 3'b010,
        D_HOLD = 3'b100
    } ihp_dst_t;

    ihp_dst_t st_r;
    logic bclk_s, refresh_s, rstdrv_s, ce_n_s, memr_n_s, memw_n_s, ali_s, osc_s;
    logic [19:0] sa_s;
    logic [7:0] sd_s;
    logic [3:0] jmp_s;
    logic bclk_d_r;
    logic bclk_rise;
    logic [7:0] lat_lo_r;
    logic [7:0] a_lo;
    logic [13:0] ofs;
    logic sel;
    logic [5:0] base_r;
    logic [7:0] ctrl_r;
    logic [3:0] irq_sel_r;
    logic code_ok;
    logic [13:0] acc_ofs_r;
    logic acc_wr_r;
    logic [1:0] cnt_r;
    logic do_acc;
    logic in_code;
    logic in_dp;
    logic [11:0] code_idx;
    logic [7:0] dp_idx;
    logic [7:0] dp_mem [DP_DEPTH];
    logic [7:0] code_mem [CODE_DEPTH];

    ////////////////////////////////////////////////////////////////////////////
    // Pin sampling; the bus clock is only sampled, never used as a clock
    ihp_sync3 #(.W(8), .INIT(8'h3e)) u_sync_ctl (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d({bus.bclk, bus.refresh, bus.rstdrv, bus.ce_n, bus.memr_n, bus.memw_n,
            bus.addr_latch_select_in, osc_input}),
        .q({bclk_s, refresh_s, rstdrv_s, ce_n_s, memr_n_s, memw_n_s, ali_s, osc_s})
    );
    ihp_sync3 #(.W(32), .INIT(32'h0)) u_sync_dat (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d({bus.sa, bus.sd, base_select_jumpers}),
        .q({sa_s, sd_s, jmp_s})
    );

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bclk_d_r <= 1'b0;
        end else if (clk_en) begin
            bclk_d_r <= bclk_s;
        end
    end
    assign bclk_rise = bclk_s & ~bclk_d_r;

    ////////////////////////////////////////////////////////////////////////////
    // Address path and decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_lo_r <= 8'h00;
        end else if (clk_en && ali_s) begin
            lat_lo_r <= sa_s[7:0];
        end
    end
    assign a_lo = ali_s ? sa_s[7:0] : lat_lo_r;
    assign ofs = {sa_s[13:8], a_lo};
    // Refresh and deselected cycles never start an access
    assign sel = (sa_s[19:14] == base_r) & ~ce_n_s & ~refresh_s;
    assign code_ok = ~ctrl_r[RUN_BIT] & ctrl_r[GATE_BIT];
    assign in_code = (acc_ofs_r >= CODE_OFS) && ({18'h0, acc_ofs_r - CODE_OFS} < CODE_DEPTH);
    assign in_dp = {18'h0, acc_ofs_r} < DP_DEPTH;
    assign code_idx = acc_ofs_r[11:0];
    assign dp_idx = acc_ofs_r[7:0];

    ////////////////////////////////////////////////////////////////////////////
    // Host cycle sequencer
    assign do_acc = (st_r == D_BUSY) && bclk_rise && ({30'h0, cnt_r} == DEV_WAIT_BCLK - 1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= D_IDLE;
            cnt_r <= 2'd0;
            acc_ofs_r <= 14'h0;
            acc_wr_r <= 1'b0;
            bus.chrdy_oe <= 1'b0;
            bus.d_sd_oe <= 1'b0;
        end else if (clk_en) begin
            case (st_r)
                D_IDLE: begin
                    if (bclk_rise && sel && (!memr_n_s || !memw_n_s)) begin
                        st_r <= D_BUSY;
                        cnt_r <= 2'd0;
                        acc_ofs_r <= ofs;
                        acc_wr_r <= ~memw_n_s;
                        bus.chrdy_oe <= 1'b1;
                    end
                end
                D_BUSY: begin
                    if (do_acc) begin
                        st_r <= D_HOLD;
                        bus.chrdy_oe <= 1'b0;
                        bus.d_sd_oe <= ~acc_wr_r;
                    end else if (bclk_rise) begin
                        cnt_r <= cnt_r + 2'd1;
                    end
                end
                D_HOLD: begin
                    // Data stays on the bus until the strobe goes away
                    if (memr_n_s && memw_n_s) begin
                        st_r <= D_IDLE;
                        bus.d_sd_oe <= 1'b0;
                    end
                end
                default: begin
                    st_r <= D_IDLE;
                    bus.chrdy_oe <= 1'b0;
                    bus.d_sd_oe <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.d_sd_o <= LOCKED_RDATA;
        end else if (clk_en && do_acc && !acc_wr_r) begin
            if (in_code) begin
                bus.d_sd_o <= code_ok ? code_mem[code_idx] : LOCKED_RDATA;
            end else if (in_dp) begin
                bus.d_sd_o <= dp_mem[dp_idx];
            end else begin
                bus.d_sd_o <= LOCKED_RDATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memories; host wins a same-cycle clash on the shared RAM
    always_ff @(posedge pclk) begin
        if (clk_en) begin
            if (do_acc && acc_wr_r && in_dp) begin
                dp_mem[dp_idx] <= sd_s;
            end else if (core_dp_we) begin
                dp_mem[core_dp_addr] <= core_dp_wdata;
            end
            core_dp_rdata <= dp_mem[core_dp_addr];
        end
    end

    always_ff @(posedge pclk) begin
        if (clk_en) begin
            if (do_acc && acc_wr_r && in_code && code_ok) begin
                code_mem[code_idx] <= sd_s;
            end
            core_code_byte <= code_mem[core_pc];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, written only from the host side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= CTRL_RST;
            irq_sel_r <= IRQ_SEL_RST;
        end else if (clk_en) begin
            if (rstdrv_s) begin
                ctrl_r <= CTRL_RST;
                irq_sel_r <= IRQ_SEL_RST;
            end else if (do_acc && acc_wr_r && acc_ofs_r <= CREG_LAST_OFS) begin
                if (acc_ofs_r == CREG_CTRL_OFS) begin
                    ctrl_r <= sd_s;
                end
                if (acc_ofs_r == CREG_IRQ_OFS) begin
                    irq_sel_r <= sd_s[3:0];
                end
            end
        end
    end

    // Straps are followed while reset is driven, so no reset-time pin capture is needed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            base_r <= BASE_RST;
        end else if (clk_en) begin
            if (rstdrv_s) begin
                base_r <= ihp_base_of(jmp_s);
            end else if (base_sw_we) begin
                base_r <= base_sw_data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Core side
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n <= 1'b0;
            core_mode <= 2'b00;
            core_pc <= 12'h000;
        end else if (clk_en) begin
            core_reset_n <= ctrl_r[RUN_BIT];
            core_mode <= ctrl_r[MODE_LSB +: 2];
            if (!ctrl_r[RUN_BIT]) begin
                core_pc <= 12'h000;
            end else if (core_jump) begin
                core_pc <= core_jump_addr;
            end else if (core_fetch_next) begin
                core_pc <= core_pc + 12'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            muxed_low_port <= 8'h00;
            upper_addr_port <= 8'h00;
            ext_sel_n <= 1'b1;
            clk_out <= 1'b0;
        end else if (clk_en) begin
            muxed_low_port <= ext_addr_phase ? ext_addr[7:0] : ext_wdata;
            upper_addr_port <= ext_addr[15:8];
            ext_sel_n <= ~ext_select_port_bit;
            clk_out <= osc_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt lines only ever pull low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.irq_o <= '0;
            bus.chrdy_o <= 1'b0;
        end else if (clk_en) begin
            bus.irq_o <= '0;
            bus.chrdy_o <= 1'b0;
        end
    end

    for (genvar i = 0; i < N_IRQ; i++) begin : g_irq
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                bus.irq_oe[i] <= 1'b0;
            end else if (clk_en) begin
                bus.irq_oe[i] <= ctrl_r[IRQ_EN_BIT] & core_irq_req & (irq_sel_r == IRQ_NUMS[4*i +: 4]);
            end
        end
    end
endmodule
`default_nettype wire

// ---- src/ihp_host.sv ----
`default_nettype none
module ihp_host
    import ihp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    ihp_bus_if.host bus
);
    typedef enum logic [3:0] {
        H_IDLE = 4'b0001,
        H_ADR = 4'b0010,
        H_STB = 4'b0100,
        H_END = 4'b1000
    } ihp_hst_t;

    ihp_hst_t st_r;
    logic [19:0] addr_r;
    logic [7:0] wdata_r;
    logic [4:0] ctrl_r;
    logic [7:0] rdata_r;
    logic pend_r;
    logic [3:0] div_r;
    logic fall;
    logic [1:0] cnt_r;
    logic chrdy_s;
    logic [7:0] sd_s;
    logic [10:0] irq_s;
    logic wr_acc;
    logic mapped;

    ihp_sync3 #(.W(20), .INIT(20'hfffff)) u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .clk_en(clk_en),
        .d({bus.chrdy, bus.sd, bus.irq}),
        .q({chrdy_s, sd_s, irq_s})
    );

    ////////////////////////////////////////////////////////////////////////////
    // Bus clock divider
    assign fall = ({28'h0, div_r} == BCLK_HALF_CYC - 1) && bus.bclk;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_r <= 4'h0;
            bus.bclk <= 1'b0;
        end else if (clk_en) begin
            if ({28'h0, div_r} == BCLK_HALF_CYC - 1) begin
                div_r <= 4'h0;
                bus.bclk <= ~bus.bclk;
            end else begin
                div_r <= div_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: one wait state, so read data leaves a flip-flop
    assign wr_acc = psel & penable & pready & pwrite;
    assign mapped = paddr == H_ADDR_OFS || paddr == H_WDATA_OFS || paddr == H_CTRL_OFS ||
                    paddr == H_STAT_OFS || paddr == H_IRQ_OFS;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else if (clk_en) begin
            pready <= psel & penable & ~pready;
            pslverr <= psel & penable & ~pready & ~mapped;
            if (psel && penable && !pready) begin
                case (paddr)
                    H_ADDR_OFS: prdata <= {12'h0, addr_r};
                    H_WDATA_OFS: prdata <= {24'h0, wdata_r};
                    H_CTRL_OFS: prdata <= {27'h0, ctrl_r[4:1], 1'b0};
                    H_STAT_OFS: prdata <= {16'h0, rdata_r, 6'h0, chrdy_s, pend_r};
                    H_IRQ_OFS: prdata <= {21'h0, irq_s};
                    default: prdata <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            addr_r <= 20'h0;
            wdata_r <= 8'h00;
            ctrl_r <= H_CTRL_RST;
        end else if (clk_en && wr_acc) begin
            if (paddr == H_ADDR_OFS) addr_r <= pwdata[19:0];
            if (paddr == H_WDATA_OFS) wdata_r <= pwdata[7:0];
            if (paddr == H_CTRL_OFS) ctrl_r <= {pwdata[4:1], 1'b0};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle sequencer, steps on falling bus clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= H_IDLE;
            pend_r <= 1'b0;
            cnt_r <= 2'd0;
            rdata_r <= 8'h00;
            bus.sa <= 20'h0;
            bus.ce_n <= 1'b1;
            bus.memr_n <= 1'b1;
            bus.memw_n <= 1'b1;
            bus.refresh <= 1'b0;
            bus.h_sd_o <= 8'h00;
            bus.h_sd_oe <= 1'b0;
            bus.addr_latch_select_in <= 1'b1;
            bus.rstdrv <= 1'b1;
        end else if (clk_en) begin
            bus.rstdrv <= ctrl_r[H_RST];
            // A start while a cycle is pending is dropped
            if (wr_acc && paddr == H_CTRL_OFS && pwdata[H_GO]) begin
                pend_r <= 1'b1;
            end
            case (st_r)
                H_IDLE: if (fall && pend_r) begin
                    st_r <= H_ADR;
                    bus.sa <= addr_r;
                    bus.ce_n <= 1'b0;
                    bus.refresh <= ctrl_r[H_RFSH];
                    bus.addr_latch_select_in <= 1'b1;
                    bus.h_sd_o <= wdata_r;
                    bus.h_sd_oe <= ctrl_r[H_WR] & ~ctrl_r[H_RFSH];
                end
                H_ADR: if (fall) begin
                    st_r <= H_STB;
                    cnt_r <= 2'd0;
                    bus.memw_n <= ~(ctrl_r[H_WR] & ~ctrl_r[H_RFSH]);
                    bus.memr_n <= ctrl_r[H_WR] & ~ctrl_r[H_RFSH];
                    if (!ctrl_r[H_ALI]) begin
                        // Multiplexed mode: low address lines no longer carry address
                        bus.addr_latch_select_in <= 1'b0;
                        bus.sa[7:0] <= 8'h00;
                    end
                end
                H_STB: if (fall) begin
                    if ({30'h0, cnt_r} < STROBE_BCLK - 1) begin
                        cnt_r <= cnt_r + 2'd1;
                    end else if (chrdy_s) begin
                        st_r <= H_END;
                        rdata_r <= sd_s;
                        bus.memr_n <= 1'b1;
                        bus.memw_n <= 1'b1;
                    end
                end
                H_END: if (fall) begin
                    st_r <= H_IDLE;
                    pend_r <= 1'b0;
                    bus.ce_n <= 1'b1;
                    bus.refresh <= 1'b0;
                    bus.h_sd_oe <= 1'b0;
                    bus.addr_latch_select_in <= 1'b1;
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

// ---- verif/ihp_chk.sv ----
`default_nettype none
module ihp_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce_n,
    input wire logic memr_n,
    input wire logic refresh,
    input wire logic rstdrv,
    input wire logic d_sd_oe,
    input wire logic chrdy_oe,
    input wire logic [10:0] irq_oe
);
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////
    // Eight quiet cycles cover the synchroniser lag on the bus pins
    sequence quiet_cs;
        ce_n [*8];
    endsequence
    sequence no_read;
        memr_n [*8];
    endsequence
    chk_cs_nodata: assert property (quiet_cs |-> !d_sd_oe) else $error("data driven unselected");
    chk_cs_nowait: assert property (quiet_cs |-> !chrdy_oe) else $error("ready pulled unselected");
    chk_write_nodrive: assert property (no_read |-> !d_sd_oe) else $error("data driven without read");
    chk_rfsh_nodata: assert property (refresh [*8] |-> !d_sd_oe) else $error("data in refresh");
    chk_wait_bound: assert property ($rose(chrdy_oe) |-> ##[1:60] !chrdy_oe) else $error("stretch stuck");
    chk_data_holds: assert property (d_sd_oe && !memr_n |=> d_sd_oe) else $error("data dropped early");
    chk_irq_one: assert property ($onehot0(irq_oe)) else $error("several requests pulled");
    chk_rst_irq: assert property (rstdrv [*8] |-> irq_oe == 11'h000) else $error("request in reset");
endmodule
`default_nettype wire

// ---- verif/tb_isa_host_port_reset_decode.sv ----
`default_nettype none
module tb_isa_host_port_reset_decode
    import ihp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [5:0] BASE_HI = 6'h36;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic en = 1'b1;
    logic [15:0] z = 16'h0000;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, r, q;
    logic pready, core_reset_n, ext_sel_n, clk_out;
    logic [15:0] xa = 16'h0000;
    logic ph = 1'b0;
    logic [3:0] base_select_jumpers = 4'ha;
    logic ext_select_port_bit = 1'b0;
    logic core_irq_req = 1'b0;
    logic [11:0] core_pc;
    logic [7:0] core_code_byte, mlp, uap;
    int mismatches = 0;
    int cmp_count = 0;
    int cyc = 0;
    always #5 pclk = ~pclk;
    ihp_bus_if bus ();
    ihp_host u_ihp_host (.pclk, .presetn, .clk_en(en), .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr(), .bus(bus.host));
    ihp_device u_ihp_device (.pclk, .presetn, .clk_en(en), .bus(bus.dev), .base_select_jumpers,
        .osc_input(bus.bclk), .ext_select_port_bit, .core_irq_req, .core_dp_addr(z[7:0]), .core_dp_we(z[0]),
        .core_dp_wdata(z[7:0]), .core_dp_rdata(), .core_fetch_next(z[0]), .core_jump(z[0]),
        .core_jump_addr(z[11:0]), .core_pc, .core_code_byte, .core_reset_n, .core_mode(), .base_sw_we(z[0]),
        .base_sw_data(z[5:0]), .ext_addr(xa), .ext_wdata(xa[15:8]), .ext_addr_phase(ph), .muxed_low_port(mlp),
        .upper_addr_port(uap), .ext_sel_n, .clk_out);
    ihp_chk u_ihp_chk (.pclk, .presetn, .ce_n(bus.ce_n), .memr_n(bus.memr_n), .refresh(bus.refresh),
        .rstdrv(bus.rstdrv), .d_sd_oe(bus.d_sd_oe), .chrdy_oe(bus.chrdy_oe), .irq_oe(bus.irq_oe));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask
    // One idle edge first, so no signal is driven twice in one step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] rd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Bus cycle via host: control bit4 direct address, bit1 write, bit2 refresh
    task automatic isa(input logic [19:0] a, input logic [7:0] d, input logic [4:0] c, output logic [31:0] o);
        logic [31:0] s;
        apb(1'b1, H_ADDR_OFS, {12'h000, a}, s);
        apb(1'b1, H_WDATA_OFS, {24'h000000, d}, s);
        apb(1'b1, H_CTRL_OFS, {27'h0000000, c} | 32'h0000_0001, s);
        s = 32'h0000_0001;
        while (s[0] !== 1'b0) apb(1'b0, H_STAT_OFS, 32'h0000_0000, s);
        o = {24'h000000, s[15:8]};
    endtask
    function automatic logic [19:0] ha(input logic [13:0] o);
        return {BASE_HI, o};
    endfunction
    task automatic print_verdict;
        $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
        if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, H_CTRL_OFS, 32'h0000_0010, r);
        isa(ha(14'h0020), 8'h5a, 5'h12, q);
        isa(ha(14'h0020), 8'h00, 5'h10, q);
        chk(32'h5a, q);
        isa({6'h35, 14'h0020}, 8'h11, 5'h12, q);
        isa({6'h35, 14'h0020}, 8'h00, 5'h10, q);
        chk(32'hff, q);
        isa(ha(14'h0020), 8'h00, 5'h14, q);
        chk(32'hff, q);
        isa(ha(14'h0020), 8'h00, 5'h10, q);
        chk(32'h5a, q);
        // Multiplexed write, direct read back, then multiplexed read
        isa(ha(14'h0021), 8'h3e, 5'h02, q);
        isa(ha(14'h0021), 8'h00, 5'h10, q);
        chk(32'h3e, q);
        isa(ha(14'h0020), 8'h00, 5'h00, q);
        chk(32'h5a, q);
        isa(ha(14'h0003), 8'h77, 5'h12, q);
        isa(ha(14'h0003), 8'h00, 5'h10, q);
        chk(32'h77, q);
        isa(ha(14'h0000), 8'h10, 5'h12, q);
        isa(ha(CODE_OFS), 8'ha5, 5'h12, q);
        isa(ha(CODE_OFS), 8'h00, 5'h10, q);
        chk(32'ha5, q);
        chk(32'h0, {31'h0, core_reset_n});
        isa(ha(14'h0000), 8'h11, 5'h12, q);
        repeat (4) @(posedge pclk);
        chk(32'h1, {31'h0, core_reset_n});
        chk(32'h000a_5000, {12'h000, core_code_byte, core_pc});
        isa(ha(CODE_OFS), 8'h3c, 5'h12, q);
        isa(ha(CODE_OFS), 8'h00, 5'h10, q);
        chk(32'hff, q);
        isa(ha(14'h0000), 8'h10, 5'h12, q);
        isa(ha(CODE_OFS), 8'h00, 5'h10, q);
        chk(32'ha5, q);
        isa(ha(14'h0000), 8'h00, 5'h12, q);
        isa(ha(CODE_OFS), 8'h00, 5'h10, q);
        chk(32'hff, q);
        ext_select_port_bit <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(32'h0, {31'h0, ext_sel_n});
        @(posedge clk_out);
        repeat (3) @(posedge pclk);
        chk(32'h1, {31'h0, clk_out});
        repeat (6) @(posedge pclk);
        chk(32'h0, {31'h0, clk_out});
        xa <= 16'hc35a;
        ph <= 1'b1;
        repeat (2) @(posedge pclk);
        chk(32'hc35a, {16'h0, uap, mlp});
        ph <= 1'b0;
        repeat (2) @(posedge pclk);
        chk(32'hc3c3, {16'h0, uap, mlp});
        // Line 5 is output index 2, pulled low while enabled and requested
        isa(ha(14'h0001), 8'h05, 5'h12, q);
        isa(ha(14'h0000), 8'h08, 5'h12, q);
        core_irq_req <= 1'b1;
        repeat (8) @(posedge pclk);
        apb(1'b0, H_IRQ_OFS, 32'h0, r);
        chk(32'h0000_07fb, r);
        isa(ha(14'h0000), 8'h19, 5'h12, q);
        apb(1'b1, H_CTRL_OFS, 32'h0000_0018, r);
        repeat (20) @(posedge pclk);
        apb(1'b1, H_CTRL_OFS, 32'h0000_0010, r);
        repeat (20) @(posedge pclk);
        chk(32'h0, {31'h0, core_reset_n});
        apb(1'b0, H_IRQ_OFS, 32'h0, r);
        chk(32'h0000_07ff, r);
        print_verdict();
    end
endmodule
`default_nettype wire
